// file: daq_flags_pkg.sv
// Constants and types for the acquisition control and FIFO flag block
package daq_flags_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W = 19;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 19'h40000;
  localparam int OFS_W = 18;
  localparam logic [OFS_W-1:0] OFS_DEFAULT = 18'h003ff;
  localparam int SHIFT_LEN = 36;
  localparam logic [5:0] SHIFT_LAST = 6'h23;

  localparam logic [ADDR_W-1:0] ADR_CTRL_ONE = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_CTRL_TWO = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_TRIG = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_IN_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] ADR_OUT_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_IN_SHIFT = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_OUT_SHIFT = 4'h6;
  localparam logic [ADDR_W-1:0] ADR_IRQ_SEL0 = 4'h7;
  localparam logic [ADDR_W-1:0] ADR_IRQ_SEL1 = 4'h8;

  // acq_control_one field positions
  localparam int F_IN_MODE = 0;
  localparam int F_OUT_MODE = 2;
  localparam int F_IN_FMT = 4;
  localparam int F_OUT_FMT = 6;
  // acq_control_two bits
  localparam int B_IN_RUN = 0;
  localparam int B_OUT_RUN = 1;
  localparam int B_IN_ABORT = 2;
  localparam int B_OUT_ABORT = 3;
  // acq_trigger_control bits
  localparam int B_MASTER = 0;
  localparam int B_IN_SRC = 1;
  localparam int B_OUT_SRC = 2;
  localparam int B_SENSE = 3;
  localparam int B_STREAM = 4;
  localparam int B_IN_TSEL = 5;
  localparam int B_OUT_TSEL = 6;
  localparam logic [7:0] TRIG_RESET = 8'h01;

  localparam logic [1:0] MODE_CFG = 2'h0;
  localparam logic [1:0] MODE_ONE_PASS = 2'h3;
  localparam logic [1:0] FMT_FIRST = 2'h1;
  localparam logic [1:0] FMT_SECOND = 2'h2;
  localparam logic [1:0] FMT_RESET = 2'h3;

  typedef enum logic [1:0] {
    M_CONFIG = 2'h0,
    M_PASS_THROUGH = 2'h1,
    M_ONE_PASS = 2'h2
  } op_mode_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ARMED = 4'b0010,
    S_RUN = 4'b0100,
    S_DONE = 4'b1000
  } acq_state_t;

  typedef struct packed {
    logic partly_full_flag;
    logic full_flag;
    logic partly_empty_flag;
    logic empty_flag;
  } fifo_flags_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// file: daq_fifo_flags_and_mode_control.sv
// Acquisition mode control, start triggering and FIFO status flags
//
// Notes on behaviour
// R1 - Each direction runs in configuration, one-pass or pass-through mode.
// R2 - Flag offsets load only in configuration mode, used in other modes.
// R3 - One-pass output sends preloaded words to converters or digital stream.
// R4 - Pass-through never ends by itself; only an abort stops it. Here a return to configuration mode also stops it.
// R5 - Host keeps the output FIFO fed during pass-through.
// R6 - Counters, controllers and transfer logic work only in active modes.
// R7 - Input format picks first, second or both channels, and transfer flags.
// R8 - Output format picks first, second or both channels, and transfer flags.
// R9 - One master/slave bit sets the sync role for both controllers.
// R10 - Software input start begins at run; otherwise waits external trigger.
// R11 - Software output start begins at run; otherwise waits external trigger.
// R12 - Edge sense starts acquisition on trigger falling edge.
// R13 - Level sense starts acquisition while trigger is low.
// R14 - Four FIFOs each give empty, partly-empty, full, partly-full status bits.
// R15 - Empty ends input transfer; ends one-pass output, starts output transfer.
// R16 - Partly-empty set at N or fewer words, clear above N.
// R17 - Partly-empty offset resets to 1023, programmable below the depth.
// R18 - Partly-empty may end input transfer or one-pass output.
// R19 - Full may end one-pass input, start input transfer, end output transfer.
// R20 - Partly-full set at depth minus M or more, clear below.
// R21 - Partly-full may end one-pass input, start input, end output transfer.
// R22 - Any flag may be routed to either interrupt request line.
// R23 - Mode code zero is configuration, entered at reset.
// R24 - Partly-full offset resets to 1023, reprogrammed only in configuration.
// R25 - Host sends 36 one-bit writes, partly-empty LSB first.
// R26 - New offsets take effect only after the 36th write.
// R27 - Flags follow the word count on the edge after each access.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module daq_fifo_flags_and_mode_control (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [daq_flags_pkg::ADDR_W-1:0] i_addr,
  input wire logic [daq_flags_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [daq_flags_pkg::DATA_W-1:0] o_rdata,
  input wire logic [1:0] i_in_conv_wr,
  input wire logic [1:0] i_in_host_rd,
  input wire logic [1:0] i_out_host_wr,
  input wire logic [1:0] i_out_conv_rd,
  input wire logic i_input_ext_trigger,
  input wire logic i_output_ext_trigger,
  input wire logic i_sync_run,
  output logic o_sync_master,
  output logic o_sync_run,
  output logic o_in_acq_run,
  output logic o_out_acq_run,
  output logic [1:0] o_in_chan_en,
  output logic [1:0] o_out_chan_en,
  output logic o_out_to_ext_stream,
  output logic o_in_xfer_req,
  output logic o_out_xfer_req,
  output logic [1:0] o_irq_req
);
  import daq_flags_pkg::*;

  reg_req_t req;
  logic [7:0] ctrl_one_q;
  logic [7:0] trig_ctrl_q;
  logic [15:0] irq_sel_q [2];
  logic [OFS_W-1:0] ofs_pe_q [2];
  logic [OFS_W-1:0] ofs_pf_q [2];
  logic [SHIFT_LEN-1:0] shift_q [2];
  logic [5:0] shift_cnt_q [2];
  logic [CNT_W-1:0] cnt_q [4];
  logic [CNT_W-1:0] cnt_d [4];
  fifo_flags_t flags_q [4];
  acq_state_t state_q [2];
  acq_state_t state_d [2];
  logic [1:0] trig_prev_q;
  logic [1:0] xfer_q;
  logic [1:0] mode [2];
  logic [1:0] fmt [2];
  logic [1:0] chan_en [2];
  logic [1:0] active;
  logic [1:0] run_wr;
  logic [1:0] abort_wr;
  logic [1:0] shift_wr;
  logic [1:0] trig_now;
  logic [1:0] trig_ok;
  logic [1:0] ext_src;
  logic [1:0] tsel;
  logic [1:0] term;
  logic [1:0] xfer_start;
  logic [1:0] xfer_stop;
  logic [3:0] fifo_wr;
  logic [3:0] fifo_rd;
  logic [15:0] flag_vec;
  logic sync_ok;

  function automatic op_mode_t decode_mode(input logic [1:0] code);
    if (code == MODE_CFG) begin
      return M_CONFIG;
    end else if (code == MODE_ONE_PASS) begin
      return M_ONE_PASS;
    end
    return M_PASS_THROUGH;
  endfunction

  function automatic logic [1:0] decode_fmt(input logic [1:0] code);
    if (code == FMT_FIRST) begin
      return 2'h1;
    end else if (code == FMT_SECOND) begin
      return 2'h2;
    end
    return 2'h3;
  endfunction

  function automatic fifo_flags_t calc_flags(input logic [CNT_W-1:0] cnt,
      input logic [OFS_W-1:0] n, input logic [OFS_W-1:0] m);
    fifo_flags_t f;
    f.empty_flag = (cnt == '0); // R15
    f.partly_empty_flag = (cnt <= {1'b0, n}); // R16
    f.full_flag = (cnt == FIFO_DEPTH); // R19
    f.partly_full_flag = (cnt >= FIFO_DEPTH - {1'b0, m}); // R20
    return f;
  endfunction

  // Any enabled channel raising the chosen flag counts
  function automatic logic any_flag(input fifo_flags_t a, input fifo_flags_t b,
      input logic [1:0] en, input logic [1:0] which);
    logic fa;
    logic fb;
    fa = which[1] ? (which[0] ? a.partly_full_flag : a.full_flag)
                  : (which[0] ? a.partly_empty_flag : a.empty_flag);
    fb = which[1] ? (which[0] ? b.partly_full_flag : b.full_flag)
                  : (which[0] ? b.partly_empty_flag : b.empty_flag);
    return (en[0] & fa) | (en[1] & fb);
  endfunction

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  always_comb begin
    mode[0] = ctrl_one_q[F_IN_MODE +: 2];
    mode[1] = ctrl_one_q[F_OUT_MODE +: 2];
    fmt[0] = ctrl_one_q[F_IN_FMT +: 2];
    fmt[1] = ctrl_one_q[F_OUT_FMT +: 2];
    ext_src[0] = trig_ctrl_q[B_IN_SRC];
    ext_src[1] = trig_ctrl_q[B_OUT_SRC];
    tsel[0] = trig_ctrl_q[B_IN_TSEL];
    tsel[1] = trig_ctrl_q[B_OUT_TSEL];
    trig_now[0] = i_input_ext_trigger;
    trig_now[1] = i_output_ext_trigger;
    sync_ok = trig_ctrl_q[B_MASTER] | i_sync_run; // R9
    for (int d = 0; d < 2; d++) begin
      chan_en[d] = decode_fmt(fmt[d]); // R7 R8
      active[d] = (decode_mode(mode[d]) != M_CONFIG); // R6
      run_wr[d] = req.wr && req.addr == ADR_CTRL_TWO && req.wdata[B_IN_RUN + d];
      abort_wr[d] = req.wr && req.addr == ADR_CTRL_TWO && req.wdata[B_IN_ABORT + d];
      shift_wr[d] = req.wr && req.addr == (d == 0 ? ADR_IN_SHIFT : ADR_OUT_SHIFT);
      // Low level, or high-to-low between samples
      trig_ok[d] = !ext_src[d] || (trig_ctrl_q[B_SENSE] ? !trig_now[d]
                                   : (trig_prev_q[d] && !trig_now[d])); // R10 R11 R12 R13
    end
    // Input: one-pass ends on full or partly-full; output on empty or partly-empty
    term[0] = any_flag(flags_q[0], flags_q[1], chan_en[0], {1'b1, tsel[0]}); // R19 R21
    term[1] = any_flag(flags_q[2], flags_q[3], chan_en[1], {1'b0, tsel[1]}); // R15 R18
    xfer_start[0] = term[0]; // R19 R21
    xfer_stop[0] = any_flag(flags_q[0], flags_q[1], chan_en[0], {1'b0, tsel[0]}); // R15 R18
    xfer_start[1] = term[1]; // R15 R18
    xfer_stop[1] = any_flag(flags_q[2], flags_q[3], chan_en[1], {1'b1, tsel[1]}); // R19 R21
  end

  // Acquisition controllers
  always_comb begin
    for (int d = 0; d < 2; d++) begin
      state_d[d] = state_q[d];
      unique case (state_q[d])
        S_IDLE, S_DONE: begin
          if (run_wr[d] && active[d]) begin
            state_d[d] = (trig_ok[d] && sync_ok) ? S_RUN : S_ARMED; // R10 R11
          end
        end
        S_ARMED: begin
          if (trig_ok[d] && sync_ok) begin
            state_d[d] = S_RUN; // R12 R13
          end
        end
        S_RUN: begin
          // Pass-through has no self-termination
          if (decode_mode(mode[d]) == M_ONE_PASS && term[d]) begin
            state_d[d] = S_DONE; // R3 R4
          end
        end
      endcase
      if (abort_wr[d] || !active[d]) begin
        state_d[d] = S_IDLE; // R4 R6
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_q[0] <= S_IDLE;
      state_q[1] <= S_IDLE;
      trig_prev_q <= 2'h3;
    end else begin
      state_q[0] <= state_d[0];
      state_q[1] <= state_d[1];
      trig_prev_q <= trig_now;
    end
  end

  // Word counters: converters side only while running, host side while active
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      fifo_wr[c] = i_in_conv_wr[c] && chan_en[0][c] && state_q[0] == S_RUN;
      fifo_rd[c] = i_in_host_rd[c] && active[0]; // R6
      fifo_wr[c + 2] = i_out_host_wr[c] && active[1]; // R6
      fifo_rd[c + 2] = i_out_conv_rd[c] && chan_en[1][c] && state_q[1] == S_RUN; // R3
    end
    for (int f = 0; f < 4; f++) begin
      cnt_d[f] = cnt_q[f];
      if (!active[f / 2]) begin
        cnt_d[f] = '0; // R6
      end else if (fifo_wr[f] && !flags_q[f].full_flag &&
                   !(fifo_rd[f] && !flags_q[f].empty_flag)) begin
        cnt_d[f] = cnt_q[f] + 19'h1;
      end else if (fifo_rd[f] && !flags_q[f].empty_flag &&
                   !(fifo_wr[f] && !flags_q[f].full_flag)) begin
        cnt_d[f] = cnt_q[f] - 19'h1;
      end
    end
  end

  // Flags registered from next count so they never lag the count
  always_ff @(posedge i_core_clk) begin
    for (int f = 0; f < 4; f++) begin
      if (!i_rst_b) begin
        cnt_q[f] <= '0;
        flags_q[f] <= '{partly_full_flag: 1'b0, full_flag: 1'b0,
                        partly_empty_flag: 1'b1, empty_flag: 1'b1};
      end else begin
        cnt_q[f] <= cnt_d[f];
        flags_q[f] <= calc_flags(cnt_d[f], ofs_pe_q[f / 2], ofs_pf_q[f / 2]); // R14 R27
      end
    end
  end

  // Serial offset load, one bit per write, both FIFOs of a direction together
  always_ff @(posedge i_core_clk) begin
    for (int d = 0; d < 2; d++) begin
      if (!i_rst_b) begin
        ofs_pe_q[d] <= OFS_DEFAULT; // R17
        ofs_pf_q[d] <= OFS_DEFAULT; // R24
        shift_q[d] <= '0;
        shift_cnt_q[d] <= '0;
      end else if (decode_mode(mode[d]) != M_CONFIG) begin
        shift_cnt_q[d] <= '0; // R2
      end else if (shift_wr[d]) begin
        // Partly-empty LSB arrives first, so shift toward bit zero
        shift_q[d] <= {req.wdata[0], shift_q[d][SHIFT_LEN-1:1]}; // R25
        if (shift_cnt_q[d] == SHIFT_LAST) begin
          shift_cnt_q[d] <= '0;
          ofs_pe_q[d] <= shift_q[d][OFS_W:1]; // R26
          ofs_pf_q[d] <= {req.wdata[0], shift_q[d][SHIFT_LEN-1:OFS_W+1]}; // R26
        end else begin
          shift_cnt_q[d] <= shift_cnt_q[d] + 6'h1;
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      ctrl_one_q <= {FMT_RESET, FMT_RESET, MODE_CFG, MODE_CFG}; // R23
      trig_ctrl_q <= TRIG_RESET;
      irq_sel_q[0] <= '0;
      irq_sel_q[1] <= '0;
    end else if (req.wr) begin
      unique case (req.addr)
        ADR_CTRL_ONE: ctrl_one_q <= req.wdata[7:0]; // R1
        ADR_TRIG: trig_ctrl_q <= req.wdata[7:0]; // R9
        ADR_IRQ_SEL0: irq_sel_q[0] <= req.wdata; // R22
        ADR_IRQ_SEL1: irq_sel_q[1] <= req.wdata; // R22
        default: ;
      endcase
    end
  end

  // Host transfer request: start flag sets, stop flag clears, start wins
  always_ff @(posedge i_core_clk) begin
    for (int d = 0; d < 2; d++) begin
      if (!i_rst_b || !active[d]) begin
        xfer_q[d] <= 1'b0; // R6
      end else if (xfer_start[d]) begin
        xfer_q[d] <= 1'b1; // R15 R19
      end else if (xfer_stop[d]) begin
        xfer_q[d] <= 1'b0; // R15 R19
      end
    end
  end

  assign flag_vec = {flags_q[3], flags_q[2], flags_q[1], flags_q[0]};

  // Read port: data valid the cycle after the strobe only
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || !req.rd) begin
      o_rdata <= '0;
    end else begin
      unique case (req.addr)
        ADR_CTRL_ONE: o_rdata <= {8'h00, ctrl_one_q};
        ADR_CTRL_TWO: o_rdata <= {8'h00, state_q[1], state_q[0]};
        ADR_TRIG: o_rdata <= {8'h00, trig_ctrl_q};
        ADR_IN_STAT: o_rdata <= {8'h00, flag_vec[7:0]}; // R14
        ADR_OUT_STAT: o_rdata <= {8'h00, flag_vec[15:8]}; // R14
        ADR_IRQ_SEL0: o_rdata <= irq_sel_q[0];
        ADR_IRQ_SEL1: o_rdata <= irq_sel_q[1];
        default: o_rdata <= '0;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_sync_master <= 1'b0;
      o_sync_run <= 1'b0;
      o_in_acq_run <= 1'b0;
      o_out_acq_run <= 1'b0;
      o_in_chan_en <= '0;
      o_out_chan_en <= '0;
      o_out_to_ext_stream <= 1'b0;
      o_in_xfer_req <= 1'b0;
      o_out_xfer_req <= 1'b0;
      o_irq_req <= '0;
    end else begin
      o_sync_master <= trig_ctrl_q[B_MASTER]; // R9
      o_sync_run <= trig_ctrl_q[B_MASTER] && (state_d[0] == S_RUN || state_d[1] == S_RUN);
      o_in_acq_run <= (state_d[0] == S_RUN);
      o_out_acq_run <= (state_d[1] == S_RUN);
      o_in_chan_en <= chan_en[0]; // R7
      o_out_chan_en <= chan_en[1]; // R8
      o_out_to_ext_stream <= trig_ctrl_q[B_STREAM]; // R3
      o_in_xfer_req <= xfer_q[0];
      o_out_xfer_req <= xfer_q[1];
      o_irq_req[0] <= |(flag_vec & irq_sel_q[0]); // R22
      o_irq_req[1] <= |(flag_vec & irq_sel_q[1]); // R22
    end
  end
endmodule
`default_nettype wire

// file: daq_ctrl_asserts.sv
// Port assertions for the acquisition control block
`timescale 1ns/10ps
`default_nettype none
module daq_ctrl_asserts
  import daq_flags_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic o_sync_master,
  input wire logic o_sync_run,
  input wire logic o_in_acq_run,
  input wire logic o_out_acq_run
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence ctl_one_s;
    i_wr && i_addr == ADR_CTRL_ONE;
  endsequence
  sequence ctl_two_s;
    i_wr && i_addr == ADR_CTRL_TWO;
  endsequence
  sequence trig_s;
    i_wr && i_addr == ADR_TRIG;
  endsequence
  rdata_idle_a: assert property (!i_rd |=> o_rdata == '0)
    else $error("read data not zero outside a read");
  unmapped_rd_a: assert property (i_rd && i_addr > ADR_IRQ_SEL1 |=> o_rdata == '0)
    else $error("unmapped read returned data");
  in_abort_a: assert property (ctl_two_s ##0 i_wdata[B_IN_ABORT] |-> ##[1:3] !o_in_acq_run)
    else $error("input abort did not stop");
  out_abort_a: assert property (ctl_two_s ##0 i_wdata[B_OUT_ABORT] |-> ##[1:3] !o_out_acq_run)
    else $error("output abort did not stop");
  in_cfg_a: assert property (ctl_one_s ##0 i_wdata[1:0] == MODE_CFG |-> ##[1:4] !o_in_acq_run)
    else $error("input runs in configuration mode");
  out_cfg_a: assert property (ctl_one_s ##0 i_wdata[3:2] == MODE_CFG |-> ##[1:4] !o_out_acq_run)
    else $error("output runs in configuration mode");
  master_clr_a: assert property (trig_s ##0 !i_wdata[B_MASTER] |-> ##[1:3] !o_sync_master)
    else $error("master role not dropped");
  sync_run_a: assert property (!o_sync_master [*2] |-> !o_sync_run)
    else $error("slave drives sync run");
endmodule
bind daq_fifo_flags_and_mode_control daq_ctrl_asserts u_chk (.i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_sync_master(o_sync_master), .o_sync_run(o_sync_run),
  .o_in_acq_run(o_in_acq_run), .o_out_acq_run(o_out_acq_run));
`default_nettype wire

// file: host_dma_model.sv
// Host transfer model answering the block's transfer requests
`timescale 1ns/10ps
`default_nettype none
module host_dma_model (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_en,
  input wire logic i_slow,
  input wire logic i_in_xfer_req,
  input wire logic i_out_xfer_req,
  output logic [1:0] o_in_host_rd,
  output logic [1:0] o_out_host_wr
);
  logic [1:0] gap_q;
  logic go;
  // Slow mode moves a word every fourth cycle, like a shared bus
  assign go = !i_slow || gap_q == 2'h0;
  always_ff @(posedge i_core_clk) begin
    gap_q <= i_rst_b ? gap_q + 2'h1 : 2'h0;
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_in_host_rd <= 2'h0;
      o_out_host_wr <= 2'h0;
    end else begin
      o_in_host_rd <= {2{i_en[0] && i_in_xfer_req && go}};
      o_out_host_wr <= {2{i_en[1] && i_out_xfer_req && go}};
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for acquisition control and FIFO flags
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import daq_flags_pkg::*;
  logic clk, rst_b, wstb, rstb, rd_d, slow, otrig, itrig, srun, sm, sr, irun, orun, ext, ixr, oxr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [1:0] cwr, crd, hrd, hwr, dma_en, ich, och, irq;
  logic [5:0] sv;
  logic [31:0] lfsr;
  logic [DATA_W-1:0] exq[$];
  int err_count, total_checks;
  assign sv = {ext, sm, oxr, ixr, orun, irun};
  daq_fifo_flags_and_mode_control i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wstb), .i_rd(rstb), .o_rdata(rdata), .i_in_conv_wr(cwr),
    .i_in_host_rd(hrd), .i_out_host_wr(hwr), .i_out_conv_rd(crd), .i_input_ext_trigger(itrig),
    .i_output_ext_trigger(otrig), .i_sync_run(srun), .o_sync_master(sm), .o_sync_run(sr),
    .o_in_acq_run(irun), .o_out_acq_run(orun), .o_in_chan_en(ich), .o_out_chan_en(och),
    .o_out_to_ext_stream(ext), .o_in_xfer_req(ixr), .o_out_xfer_req(oxr), .o_irq_req(irq));
  host_dma_model u_dma (.i_core_clk(clk), .i_rst_b(rst_b), .i_en(dma_en), .i_slow(slow),
    .i_in_xfer_req(ixr), .i_out_xfer_req(oxr), .o_in_host_rd(hrd), .o_out_host_wr(hwr));
  function automatic logic [31:0] nxt(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bounded wait on one status line, a timeout ends the run
  task automatic wait_for(input int k, input logic v, input int lim);
    int i;
    // Look only at settled outputs, never in the launching time step
    @(negedge clk);
    for (i = 0; i < lim && sv[k] !== v; i++) @(negedge clk);
    chk({15'h0, sv[k]}, {15'h0, v}, $sformatf("status line %0d", k));
    if (sv[k] !== v) stop_test();
  endtask
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wstb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wstb <= 1'b0;
  endtask
  task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    rstb <= 1'b1;
    addr <= a;
    exq.push_back(e);
    @(posedge clk);
    rstb <= 1'b0;
  endtask
  // Converter pulses on both FIFOs with random spacing
  task automatic pulse(input bit o, input int n);
    repeat (n) begin
      @(posedge clk);
      if (o) crd <= 2'h3;
      else cwr <= 2'h3;
      @(posedge clk);
      crd <= 2'h0;
      cwr <= 2'h0;
      lfsr = nxt(lfsr);
      repeat (lfsr[1:0]) @(posedge clk);
    end
  endtask
  // N = 2, M = 262140; upper data bits are noise the block must ignore
  task automatic load_ofs(input logic [ADDR_W-1:0] a);
    logic [35:0] v;
    v = {18'h3fffc, 18'h00002};
    for (int i = 0; i < SHIFT_LEN; i++) begin
      lfsr = nxt(lfsr);
      bus_wr(a, {lfsr[14:0], v[i]});
    end
  endtask
  always @(posedge clk) begin
    rd_d <= rstb;
    if (rd_d && exq.size() > 0) chk(rdata, exq.pop_front(), "read data");
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst_b = 0;
    wstb = 0;
    rstb = 0;
    rd_d = 0;
    addr = '0;
    wdata = '0;
    cwr = '0;
    crd = '0;
    dma_en = '0;
    slow = 1;
    otrig = 1;
    itrig = 1;
    srun = 0;
    lfsr = 32'h431e;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    bus_rd(ADR_CTRL_ONE, 16'h00f0);
    bus_rd(ADR_TRIG, 16'h0001);
    bus_rd(ADR_IN_STAT, 16'h0033);
    bus_rd(ADR_OUT_STAT, 16'h0033);
    bus_rd(ADR_CTRL_TWO, 16'h0011);
    bus_rd(4'h9, 16'h0000);
    load_ofs(ADR_IN_SHIFT);
    load_ofs(ADR_OUT_SHIFT);
    $display("reset and offsets done");
    bus_wr(ADR_TRIG, 16'h0061);
    bus_wr(ADR_CTRL_ONE, 16'h00f1);
    bus_wr(ADR_CTRL_TWO, 16'h0001);
    wait_for(0, 1'b1, 4);
    pulse(1'b0, 3);
    bus_rd(ADR_IN_STAT, 16'h0000);
    pulse(1'b0, 1);
    bus_rd(ADR_IN_STAT, 16'h0088);
    wait_for(2, 1'b1, 4);
    dma_en <= 2'h1;
    wait_for(2, 1'b0, 40);
    dma_en <= 2'h0;
    wait_for(0, 1'b1, 1);
    bus_wr(ADR_CTRL_TWO, 16'h0004);
    wait_for(0, 1'b0, 4);
    $display("input pass-through done");
    bus_wr(ADR_CTRL_ONE, 16'h00f0);
    bus_wr(ADR_CTRL_ONE, 16'h00d3);
    repeat (2) @(negedge clk);
    chk({14'h0, ich}, 16'h0001, "input channels");
    bus_wr(ADR_CTRL_TWO, 16'h0001);
    wait_for(0, 1'b1, 4);
    pulse(1'b0, 4);
    wait_for(0, 1'b0, 4);
    bus_rd(ADR_IN_STAT, 16'h0038);
    bus_rd(ADR_CTRL_TWO, 16'h0018);
    $display("input one-pass done");
    bus_wr(ADR_TRIG, 16'h0055);
    bus_wr(ADR_CTRL_ONE, 16'h00b4);
    wait_for(5, 1'b1, 4);
    bus_wr(ADR_CTRL_TWO, 16'h0002);
    repeat (6) @(negedge clk);
    chk({15'h0, orun}, 16'h0000, "armed output");
    chk({14'h0, och}, 16'h0002, "output channels");
    @(posedge clk);
    otrig <= 1'b0;
    wait_for(1, 1'b1, 4);
    bus_wr(ADR_CTRL_TWO, 16'h0008);
    wait_for(1, 1'b0, 4);
    bus_wr(ADR_TRIG, 16'h005d);
    bus_wr(ADR_CTRL_TWO, 16'h0002);
    wait_for(1, 1'b1, 4);
    wait_for(3, 1'b1, 8);
    dma_en <= 2'h2;
    wait_for(3, 1'b0, 60);
    dma_en <= 2'h0;
    pulse(1'b1, 3);
    wait_for(3, 1'b1, 30);
    chk({15'h0, orun}, 16'h0001, "output pass-through");
    chk({15'h0, sr}, 16'h0001, "master sync run");
    bus_wr(ADR_TRIG, 16'h0002);
    wait_for(4, 1'b0, 4);
    $display("output modes done");
    // Slave: a trigger edge without the master's run level is lost
    bus_wr(ADR_CTRL_ONE, 16'h00b6);
    bus_wr(ADR_CTRL_TWO, 16'h0001);
    itrig <= 1'b0;
    repeat (4) @(negedge clk);
    chk({15'h0, irun}, 16'h0000, "slave held");
    @(posedge clk);
    itrig <= 1'b1;
    srun <= 1'b1;
    repeat (2) @(negedge clk);
    chk({15'h0, irun}, 16'h0000, "no trigger edge");
    @(posedge clk);
    itrig <= 1'b0;
    wait_for(0, 1'b1, 4);
    chk({15'h0, sr}, 16'h0000, "slave sync run");
    bus_wr(ADR_IRQ_SEL0, 16'h0001);
    bus_wr(ADR_IRQ_SEL1, 16'h0008);
    repeat (2) @(negedge clk);
    chk({14'h0, irq}, 16'h0001, "interrupt lines");
    bus_rd(ADR_IRQ_SEL1, 16'h0008);
    repeat (2) @(negedge clk);
    $display("slave start and interrupts done");
    stop_test();
  end
endmodule
`default_nettype wire
